//--- hw/msd_pkg.sv
// Package: constants and carrier types for the sequence input decoder
package msd_pkg;
    localparam int          SEQ_NUM       = 6;
    localparam int          SEL_W         = 3;
    localparam int          MAP_W         = 3;
    localparam logic [2:0]  MAP_MODE_RST  = 3'h2;
    localparam logic [2:0]  MAP_FWD_RST   = 3'h1;
    localparam logic [2:0]  MAP_PROGRAM_CHOICE_BIT_TWO_RST  = 3'h4;
    localparam logic [2:0]  MAP_CLR_RST   = 3'h5;
    localparam logic [2:0]  MAP_REV_RST   = 3'h3;
    localparam logic [2:0]  SEL_RST       = 3'h0;

    typedef enum logic [0:0] {
        MSD_MODE_TABLE = 1'b0,
        MSD_MODE_JOG   = 1'b1
    } msd_mode_t;

    typedef struct packed {
        logic [MAP_W-1:0] mode_src;
        logic [MAP_W-1:0] fwd_src;
        logic [MAP_W-1:0] program_choice_bit_two_src;
        logic [MAP_W-1:0] clr_src;
        logic [MAP_W-1:0] rev_src;
    } msd_map_t;

    typedef struct packed {
        logic             fwd_jog;
        logic             rev_jog;
        logic             jog_start;
        logic             jog_run;
    } msd_jog_t;

    typedef struct packed {
        logic [SEL_W-1:0] program_choice;
        logic             program_table_reset;
        logic             alarm_clear;
    } msd_table_t;
endpackage : msd_pkg

//--- hw/msd_sync.sv
// Two-stage synchroniser bank for the sequence input pins
`timescale 1ns/1ps
`default_nettype none
module msd_sync #(
    parameter int W = 6
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule : msd_sync
`default_nettype wire

//--- hw/msd_decoder.sv
// Mode-dependent decoder for general-purpose sequence inputs
// Function
// - Each sequence input function is mapped to a physical input by configuration.
// - Table mode: sequence input five is program choice bit two.
// - Jog mode: sequence input five going active starts jog.
// - Table mode: sequence input six going active resets table only while table stopped.
// - Either mode: sequence input six going active clears the alarm.
// - Table mode: sequence input four is program choice bit one.
// - Jog mode: reverse jog runs while reverse jog input is active.
// - Jog stops as soon as reverse jog input goes inactive.
// - Mode switch active selects table mode, inactive selects jog mode.
// - Table mode: sequence input two is program choice bit zero.
// - Jog mode: forward jog starts on active and stops on inactive.
`timescale 1ns/1ps
`default_nettype none
module msd_decoder
    import msd_pkg::*;
#(
    parameter int N = msd_pkg::SEQ_NUM
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic [N-1:0]       seq_pin,
    input  wire msd_pkg::msd_map_t  input_map,
    input  wire logic               table_stopped,
    output msd_pkg::msd_mode_t      mode,
    output msd_pkg::msd_jog_t       jog,
    output msd_pkg::msd_table_t     table_out
);
    import msd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Synchronised inputs and allocation

    localparam int FN = 5;

    logic [N-1:0]       seq_s;
    logic [MAP_W-1:0]   fn_src [FN];
    logic [FN-1:0]      fn_in;
    logic               mode_in;
    logic               fwd_in;
    logic               program_choice_bit_two_in;
    logic               clr_in;
    logic               rev_in;
    logic               program_choice_bit_two_prev_q;
    logic               clr_prev_q;
    logic               program_choice_bit_two_rise;
    logic               clr_rise;
    msd_mode_t          mode_d;
    msd_mode_t          mode_q;
    msd_jog_t           jog_d;
    msd_jog_t           jog_q;
    msd_table_t         table_d;
    msd_table_t         table_q;

    // Pins pass two flip-flops before any decode
    msd_sync #(.W(N)) u_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .pin_in   (seq_pin),
        .sync_out (seq_s)
    );

    // Pick one synchronised input by its configured index
    function automatic logic pick(input logic [N-1:0] v,
                                  input logic [MAP_W-1:0] idx);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (idx == MAP_W'(i)) begin
                r = v[i];
            end
        end
        return r;
    endfunction : pick

    // Function slots in allocation order
    always_comb begin
        fn_src[0] = input_map.mode_src;
        fn_src[1] = input_map.fwd_src;
        fn_src[2] = input_map.program_choice_bit_two_src;
        fn_src[3] = input_map.clr_src;
        fn_src[4] = input_map.rev_src;
    end

    for (genvar g = 0; g < FN; g++) begin : g_pick
        assign fn_in[g] = pick(seq_s, fn_src[g]);
    end

    always_comb begin
        mode_in = fn_in[0];
        fwd_in  = fn_in[1];
        program_choice_bit_two_in = fn_in[2];
        clr_in  = fn_in[3];
        rev_in  = fn_in[4];
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Mode switch level to operating mode
    function automatic msd_mode_t mode_of(input logic active);
        msd_mode_t m;
        m = MSD_MODE_JOG;
        if (active) begin
            m = MSD_MODE_TABLE;
        end
        return m;
    endfunction : mode_of

    // One-cycle pulse on a low-to-high transition
    function automatic logic rise_of(input logic cur,
                                     input logic prev);
        return cur & ~prev;
    endfunction : rise_of

    ////////////////////////////////////////////////////////////////////////
    // Edge history

    // Follows the mapped input, so a remap may give one edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            program_choice_bit_two_prev_q <= 1'b0;
        end else begin
            program_choice_bit_two_prev_q <= program_choice_bit_two_in;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clr_prev_q <= 1'b0;
        end else begin
            clr_prev_q <= clr_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge pulses and mode

    // Pulses and mode come from the same synchronised cycle
    always_comb begin
        program_choice_bit_two_rise = rise_of(program_choice_bit_two_in, program_choice_bit_two_prev_q);
        clr_rise  = rise_of(clr_in, clr_prev_q);
        mode_d    = mode_of(mode_in);
    end

    // Mode resets to jog, as with the switch released
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MSD_MODE_JOG;
        end else begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Jog outputs

    // Jog drive only while the mode switch is off
    always_comb begin
        jog_d = '0;
        case (mode_d)
            MSD_MODE_JOG: begin
                jog_d.fwd_jog   = fwd_in;
                jog_d.rev_jog   = rev_in;
                jog_d.jog_start = program_choice_bit_two_rise;
                jog_d.jog_run   = program_choice_bit_two_in;
            end
            default: begin
                jog_d = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            jog_q <= '0;
        end else begin
            jog_q <= jog_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program table outputs

    // Choice bits land as one word, so they never split
    always_comb begin
        table_d             = '0;
        table_d.alarm_clear = clr_rise;
        case (mode_d)
            MSD_MODE_TABLE: begin
                table_d.program_choice = {program_choice_bit_two_in,
                                          rev_in,
                                          fwd_in};
                // Reset honoured only while the table stands stopped
                table_d.program_table_reset =
                    clr_rise & table_stopped;
            end
            default: begin
                table_d.program_choice      = SEL_RST;
                table_d.program_table_reset = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            table_q <= '0;
        end else begin
            table_q <= table_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drive

    // Outputs come straight from the registers
    assign mode      = mode_q;
    assign jog       = jog_q;
    assign table_out = table_q;
endmodule : msd_decoder
`default_nettype wire

//--- test/msd_host.sv
// Host controller model driving the sequence pins
`timescale 1ns/1ps
`default_nettype none
module msd_host (
    input  wire logic [5:0] want,
    output logic      [5:0] pin
);
    // Choice bits and start change together as one level word
    assign pin = want;
endmodule : msd_host
`default_nettype wire

//--- test/msd_decoder_monitor.sv
// Port checker for the sequence input decoder
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_monitor
    import msd_pkg::*;
#(
    parameter int N = 6
) (
    input wire logic                mclk,
    input wire logic                rstn,
    input wire logic [N-1:0]        seq_pin,
    input wire msd_pkg::msd_map_t   input_map,
    input wire logic                table_stopped,
    input wire msd_pkg::msd_mode_t  mode,
    input wire msd_pkg::msd_jog_t   jog,
    input wire msd_pkg::msd_table_t table_out
);
    logic [N-1:0] a_q, b_q, c_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) {a_q, b_q, c_q} <= '0;
        else {a_q, b_q, c_q} <= {seq_pin, a_q, b_q};
    end
    wire logic         jm = !b_q[input_map.mode_src];
    wire logic [N-1:0] e  = b_q & ~c_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    mode_sel_a: assert property (mode == $past(jm))
        else $error("mode wrong");
    choice_bits_a: assert property (
        table_out.program_choice == ($past(jm) ? 3'h0 :
        $past({b_q[input_map.program_choice_bit_two_src], b_q[input_map.rev_src],
        b_q[input_map.fwd_src]}))) else $error("choice wrong");
    jog_start_a: assert property (
        jog.jog_start == $past(jm && e[input_map.program_choice_bit_two_src]))
        else $error("start wrong");
    jog_run_a: assert property (
        jog.jog_run == $past(jm && b_q[input_map.program_choice_bit_two_src]))
        else $error("run wrong");
    rev_jog_a: assert property (
        jog.rev_jog == $past(jm && b_q[input_map.rev_src]))
        else $error("reverse wrong");
    rev_stop_a: assert property (
        $fell(b_q[input_map.rev_src]) |=> !jog.rev_jog)
        else $error("reverse not stopped");
    fwd_jog_a: assert property (
        jog.fwd_jog == $past(jm && b_q[input_map.fwd_src]))
        else $error("forward wrong");
    tbl_reset_a: assert property (table_out.program_table_reset ==
        $past(!jm && table_stopped && e[input_map.clr_src]))
        else $error("reset wrong");
    alarm_clr_a: assert property (
        table_out.alarm_clear == $past(e[input_map.clr_src]))
        else $error("clear wrong");
    cover property (jog.jog_start);
    cover property (table_out.program_table_reset);
    cover property (table_out.alarm_clear && mode == MSD_MODE_JOG);
endmodule : msd_decoder_monitor
bind msd_decoder msd_decoder_monitor #(.N(N)) mon (.mclk(mclk), .rstn(rstn),
    .seq_pin(seq_pin), .input_map(input_map), .table_stopped(table_stopped),
    .mode(mode), .jog(jog), .table_out(table_out));
`default_nettype wire

//--- test/mode_dependent_sequence_input_decoder_test.sv
// Self-checking bench for the sequence input decoder
`timescale 1ns/1ps
`default_nettype none
module mode_dependent_sequence_input_decoder_test;
    import msd_pkg::*;
    logic        mclk = 0, rstn = 0, stopped = 0;
    logic  [5:0] want = 0, pin;
    logic  [7:0] st, pr, ac;
    int          n_mismatch = 0, comparisons = 0, cycles = 0;
    msd_map_t    map = '{MAP_MODE_RST, MAP_FWD_RST, MAP_PROGRAM_CHOICE_BIT_TWO_RST, MAP_CLR_RST,
                         MAP_REV_RST};
    msd_mode_t   mode;
    msd_jog_t    jog;
    msd_table_t  tbo;
    always #5 mclk = ~mclk;
    msd_host host (.want(want), .pin(pin));
    msd_decoder dut (.mclk(mclk), .rstn(rstn), .seq_pin(pin), .input_map(map),
        .table_stopped(stopped), .mode(mode), .jog(jog), .table_out(tbo));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Apply a pin word and count pulses over six cycles
    task automatic go(input logic [5:0] w);
        want = w;
        {st, pr, ac} = '0;
        repeat (6) begin
            @(negedge mclk);
            st = st + jog.jog_start;
            pr = pr + tbo.program_table_reset;
            ac = ac + tbo.alarm_clear;
        end
    endtask : go
    task automatic t_jog;
        go(6'h10); chk(st, 1);
        chk(jog.jog_run, 1);
        chk(mode, MSD_MODE_JOG);
        go(6'h08); chk(jog.rev_jog, 1);
        chk(jog.jog_run, 0);
        go(6'h00); chk(jog.rev_jog, 0);
        go(6'h02); chk(jog.fwd_jog, 1);
    endtask : t_jog
    task automatic t_table;
        go(6'h16); chk(tbo.program_choice, 5);
        chk(mode, MSD_MODE_TABLE);
        go(6'h0c); chk(tbo.program_choice, 2);
        chk(jog.rev_jog, 0);
    endtask : t_table
    task automatic t_clear;
        go(6'h24); chk(pr, 0);
        chk(ac, 1);
        go(6'h04); stopped = 1;
        go(6'h24); chk(pr, 1);
        go(6'h00); go(6'h20); chk(ac, 1);
        chk(pr, 0);
    endtask : t_clear
    task automatic t_map;
        map.program_choice_bit_two_src = 3'h0;
        go(6'h01); chk(st, 1);
    endtask : t_map
    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            conclude;
        end
    end
    initial begin
        repeat (20) @(negedge mclk);
        rstn = 1;
        t_jog; t_table; t_clear; t_map;
        conclude;
    end
endmodule : mode_dependent_sequence_input_decoder_test
`default_nettype wire
